/* rtl/oag_defines.svh */
// constants for the operand address generator: offsets, fields, resets
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH

// register file indices of the three pointer pairs (low byte)
`define OAG_X_LO_IDX    5'h1A
`define OAG_Y_LO_IDX    5'h1C
`define OAG_Z_LO_IDX    5'h1E

// data space map
`define OAG_REGF_TOP    24'h00001F
`define OAG_IO_BASE     24'h000020
`define OAG_EXTIO_LO    24'h000060
`define OAG_EXTIO_HI    24'h0000FF

// avalon byte offsets
`define OAG_OFS_XPAGE   5'h00
`define OAG_OFS_YPAGE   5'h04
`define OAG_OFS_ZPAGE   5'h08
`define OAG_OFS_DPAGE   5'h0C
`define OAG_OFS_JPAGE   5'h10
`define OAG_OFS_LADDR   5'h14
`define OAG_OFS_LPC     5'h18

// reset values
`define OAG_PAGE_RST    8'h00
`define OAG_ADDR_RST    24'h000000
`define OAG_PC_RST      22'h000000

// field widths
`define OAG_BIT_W       3
`define OAG_DISP_W      6
`define OAG_IO_W        6
`define OAG_PTR_W       16
`define OAG_PAGE_W      8

`endif

/* rtl/oag_pkg.sv */
// types shared by the operand address generator
package oag_pkg;
`include "oag_defines.svh"

    typedef enum logic [3:0] {
        M_REG1        = 4'h0,
        M_REG2        = 4'h1,
        M_IO          = 4'h2,
        M_DIRECT      = 4'h3,
        M_IND         = 4'h4,
        M_DISP        = 4'h5,
        M_PREDEC      = 4'h6,
        M_POSTINC     = 4'h7,
        M_PCONST      = 4'h8,
        M_PCONST_INC  = 4'h9,
        M_EPCONST     = 4'hA,
        M_EPCONST_INC = 4'hB,
        M_PSTORE      = 4'hC,
        M_JMP         = 4'hD,
        M_PJMP        = 4'hE,
        M_EPJMP       = 4'hF
    } oag_mode_t;

    typedef enum logic [2:0] {
        SP_NONE  = 3'h0,
        SP_REGF  = 3'h1,
        SP_IO    = 3'h2,
        SP_EXTIO = 3'h3,
        SP_MEM   = 3'h4,
        SP_PROG  = 3'h5,
        SP_PC    = 3'h6
    } oag_space_t;

    typedef struct packed {
        logic [7:0]  xpg;
        logic [7:0]  ypg;
        logic [7:0]  zpg;
        logic [7:0]  dpg;
        logic [7:0]  jpg;
        logic [23:0] last_addr;
        logic [21:0] last_pc;
        logic        waitreq;
        logic [31:0] rdata;
        logic        out_valid;
        oag_space_t  space;
        logic [23:0] data_addr;
        logic [5:0]  io_addr;
        logic [2:0]  bit_sel;
        logic [4:0]  rd_addr;
        logic [4:0]  rs_addr;
        logic [4:0]  wr_addr;
        logic        wb_en;
        logic        ptr_wb_en;
        logic [4:0]  ptr_wb_idx;
        logic [15:0] ptr_wb_val;
        logic [22:0] pm_word;
        logic        pm_hi;
        logic        pc_load;
        logic [21:0] pc_val;
    } oag_state_t;

endpackage

/* rtl/oag_ptr_unit.sv */
// one pointer: pair forming, page extension, wrapped step values
`timescale 1ns/10ps
module oag_ptr_unit
#(
    parameter bit USE_PAGE = 1'b1
)
(
    input  wire logic [7:0]  lo_byte,
    input  wire logic [7:0]  hi_byte,
    input  wire logic [7:0]  page,
    output logic      [15:0] ptr,
    output logic      [23:0] ext_addr,
    output logic      [15:0] dec_val,
    output logic      [15:0] inc_val
);
    always_comb
    begin
        ptr      = {hi_byte, lo_byte};                  // [RULE_01]
        // small parts have no page register: upper byte stays zero
        ext_addr = {(USE_PAGE ? page : 8'h00), ptr};    // [RULE_20]
        // wraps modulo 2^16, the page is never carried into
        dec_val  = ptr - 16'h0001;                      // [RULE_23]
        inc_val  = ptr + 16'h0001;                      // [RULE_23]
    end
endmodule // oag_ptr_unit

/* rtl/oag_top.sv */
// operand and program address generator with avalon page registers
//
// What this block does
// [RULE_01] pointers are pairs 27:26, 29:28, 31:30
// [RULE_02] bit select comes from 3-bit field
// [RULE_03] displacement is a 6-bit unsigned field
// [RULE_04] single register: read and write destination
// [RULE_05] two registers: result only to destination
// [RULE_06] io direct uses 6-bit field, low locations
// [RULE_07] extended io reached only via data modes
// [RULE_08] direct address is the second instruction word
// [RULE_09] displacement adds to pointer, pointer unchanged
// [RULE_10] plain indirect uses pointer unmodified
// [RULE_11] data addresses 0 to 31 hit registers
// [RULE_12] pre-decrement: decrement, use, keep value
// [RULE_13] post-increment: use old value, then increment
// [RULE_14] constant read: word from bits 15:1, bit0 byte
// [RULE_15] software clears pointer bit0 before store
// [RULE_16] extended constant read prepends page register
// [RULE_17] increment forms keep byte select and page
// [RULE_18] absolute jump loads immediate target
// [RULE_19] pointer jump loads the third pointer
// [RULE_20] page registers extend pointers on large parts
// [RULE_21] direct page register extends direct addressing
// [RULE_22] jump page register extends pointer jumps
// [RULE_23] pointer write-back wraps modulo sixteen bits
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "oag_defines.svh"
module oag_top
    import oag_pkg::*;
#(
    parameter bit BIG_DATA = 1'b1,
    parameter bit BIG_PROG = 1'b1
)
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        req_valid,
    input  wire oag_mode_t   mode,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [4:0]  dst_reg,
    input  wire logic [4:0]  src_reg,
    input  wire logic [5:0]  io_field,
    input  wire logic [5:0]  disp_field,
    input  wire logic [2:0]  bit_field,
    input  wire logic [15:0] word2,
    input  wire logic [21:0] imm_target,
    input  wire logic [47:0] rf_ptr_bytes,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             out_valid,
    output oag_space_t       space,
    output logic      [23:0] data_addr,
    output logic      [5:0]  io_addr,
    output logic      [2:0]  bit_sel,
    output logic      [4:0]  rd_addr,
    output logic      [4:0]  rs_addr,
    output logic      [4:0]  wr_addr,
    output logic             wb_en,
    output logic             ptr_wb_en,
    output logic      [4:0]  ptr_wb_idx,
    output logic      [15:0] ptr_wb_val,
    output logic      [22:0] pm_word,
    output logic             pm_hi,
    output logic             pc_load,
    output logic      [21:0] pc_val
);
    oag_state_t  s_q;
    oag_state_t  s_d;
    logic [15:0] ptr_v   [3];
    logic [23:0] ext_v   [3];
    logic [15:0] dec_v   [3];
    logic [15:0] inc_v   [3];
    logic [7:0]  page_v  [3];
    logic [15:0] ptr_cur;
    logic [23:0] ext_cur;
    logic [4:0]  idx_cur;
    logic [15:0] disp_sum;
    logic [7:0]  ppage;

    assign page_v[0] = s_q.xpg;
    assign page_v[1] = s_q.ypg;
    assign page_v[2] = s_q.zpg;

    for (genvar g = 0; g < 3; g++)
    begin : g_ptr
        oag_ptr_unit #(
            .USE_PAGE (BIG_DATA)
        ) u_ptr (
            .lo_byte  (rf_ptr_bytes[16*g +: 8]),
            .hi_byte  (rf_ptr_bytes[16*g+8 +: 8]),
            .page     (page_v[g]),
            .ptr      (ptr_v[g]),
            .ext_addr (ext_v[g]),
            .dec_val  (dec_v[g]),
            .inc_val  (inc_v[g])
        );
    end

    // selector value 3 is not a pointer; it falls back to the third
    always_comb
    begin
        unique case (ptr_sel)
            2'd0:
            begin
                ptr_cur = ptr_v[0];
                ext_cur = ext_v[0];
                idx_cur = `OAG_X_LO_IDX;
                ppage   = s_q.xpg;
            end
            2'd1:
            begin
                ptr_cur = ptr_v[1];
                ext_cur = ext_v[1];
                idx_cur = `OAG_Y_LO_IDX;
                ppage   = s_q.ypg;
            end
            default:
            begin
                ptr_cur = ptr_v[2];
                ext_cur = ext_v[2];
                idx_cur = `OAG_Z_LO_IDX;
                ppage   = s_q.zpg;
            end
        endcase
        if (!BIG_DATA)
        begin
            ppage = 8'h00;
        end
    end

    assign disp_sum = ptr_cur + {10'h000, disp_field};  // [RULE_03]

    function automatic oag_space_t classify(input logic [23:0] a);
        if (a <= `OAG_REGF_TOP)
            return SP_REGF;                             // [RULE_11]
        else if (a < `OAG_EXTIO_LO)
            return SP_IO;
        else if (a <= `OAG_EXTIO_HI)
            return SP_EXTIO;                            // [RULE_07]
        else
            return SP_MEM;
    endfunction

    always_comb
    begin
        s_d           = s_q;
        s_d.out_valid = 1'b0;
        s_d.wb_en     = 1'b0;
        s_d.ptr_wb_en = 1'b0;
        s_d.pc_load   = 1'b0;
        if (req_valid)
        begin
            s_d.out_valid = 1'b1;
            s_d.bit_sel   = bit_field;                  // [RULE_02]
            s_d.rd_addr   = dst_reg;
            s_d.rs_addr   = src_reg;
            s_d.wr_addr   = dst_reg;
            s_d.space     = SP_NONE;
            s_d.pm_hi     = 1'b0;
            unique case (mode)
                M_REG1:
                begin
                    s_d.space = SP_REGF;
                    s_d.wb_en = 1'b1;                   // [RULE_04]
                end
                M_REG2:
                begin
                    s_d.space = SP_REGF;
                    s_d.wb_en = 1'b1;                   // [RULE_05]
                end
                M_IO:
                begin
                    // only 64 locations fit the field
                    s_d.space     = SP_IO;              // [RULE_06]
                    s_d.io_addr   = io_field;
                    s_d.data_addr = `OAG_IO_BASE + {18'h0, io_field};
                end
                M_DIRECT:
                begin
                    s_d.data_addr = {(BIG_DATA ? s_q.dpg : 8'h00),
                                     word2};            // [RULE_08] [RULE_21]
                end
                M_IND:
                begin
                    s_d.data_addr = ext_cur;            // [RULE_10]
                end
                M_DISP:
                begin
                    s_d.data_addr = {ppage, disp_sum};  // [RULE_09]
                end
                M_PREDEC:
                begin
                    s_d.data_addr  = {ppage, dec_v[ptr_sel == 2'd3 ?
                                     2'd2 : ptr_sel]};  // [RULE_12]
                    s_d.ptr_wb_en  = 1'b1;              // [RULE_23]
                    s_d.ptr_wb_idx = idx_cur;
                    s_d.ptr_wb_val = ptr_cur - 16'h0001;
                end
                M_POSTINC:
                begin
                    s_d.data_addr  = ext_cur;           // [RULE_13]
                    s_d.ptr_wb_en  = 1'b1;              // [RULE_23]
                    s_d.ptr_wb_idx = idx_cur;
                    s_d.ptr_wb_val = ptr_cur + 16'h0001;
                end
                M_PCONST, M_PCONST_INC, M_EPCONST, M_EPCONST_INC,
                M_PSTORE:
                begin
                    s_d.space   = SP_PROG;
                    s_d.pm_word = {8'h00, ptr_v[2][15:1]};  // [RULE_14]
                    // a store relies on software clearing bit 0
                    s_d.pm_hi   = (mode != M_PSTORE) &&
                                  ptr_v[2][0];          // [RULE_14] [RULE_15]
                    if ((mode == M_EPCONST || mode == M_EPCONST_INC)
                        && BIG_PROG)
                    begin
                        s_d.pm_word[22:15] = s_q.zpg;   // [RULE_16] [RULE_20]
                    end
                    if (mode == M_PCONST_INC || mode == M_EPCONST_INC)
                    begin
                        s_d.ptr_wb_en  = 1'b1;          // [RULE_17]
                        s_d.ptr_wb_idx = `OAG_Z_LO_IDX;
                        s_d.ptr_wb_val = inc_v[2];      // [RULE_23]
                    end
                end
                M_JMP:
                begin
                    s_d.space   = SP_PC;
                    s_d.pc_load = 1'b1;
                    s_d.pc_val  = imm_target;           // [RULE_18]
                end
                M_PJMP:
                begin
                    s_d.space   = SP_PC;
                    s_d.pc_load = 1'b1;
                    s_d.pc_val  = {6'h00, ptr_v[2]};    // [RULE_19]
                end
                M_EPJMP:
                begin
                    s_d.space   = SP_PC;
                    s_d.pc_load = 1'b1;
                    s_d.pc_val  = {(BIG_PROG ? s_q.jpg[5:0] : 6'h00),
                                   ptr_v[2]};           // [RULE_22]
                end
            endcase
            if (mode inside {M_DIRECT, M_IND, M_DISP, M_PREDEC,
                             M_POSTINC})
            begin
                s_d.space     = classify(s_d.data_addr);
                s_d.last_addr = s_d.data_addr;
            end
            if (s_d.pc_load)
            begin
                s_d.last_pc = s_d.pc_val;
            end
        end

        // avalon slave: one wait cycle, answer on the second edge
        if (!s_q.waitreq)
        begin
            s_d.waitreq = 1'b1;
            if (avs_write && avs_byteenable[0])
            begin
                unique case (avs_address)
                    `OAG_OFS_XPAGE: s_d.xpg = avs_writedata[7:0];
                    `OAG_OFS_YPAGE: s_d.ypg = avs_writedata[7:0];
                    `OAG_OFS_ZPAGE: s_d.zpg = avs_writedata[7:0];
                    `OAG_OFS_DPAGE: s_d.dpg = avs_writedata[7:0];
                    `OAG_OFS_JPAGE: s_d.jpg = avs_writedata[7:0];
                    default: ;
                endcase
            end
        end
        else if (avs_read || avs_write)
        begin
            s_d.waitreq = 1'b0;
            unique case (avs_address)
                `OAG_OFS_XPAGE: s_d.rdata = {24'h0, s_q.xpg};
                `OAG_OFS_YPAGE: s_d.rdata = {24'h0, s_q.ypg};
                `OAG_OFS_ZPAGE: s_d.rdata = {24'h0, s_q.zpg};
                `OAG_OFS_DPAGE: s_d.rdata = {24'h0, s_q.dpg};
                `OAG_OFS_JPAGE: s_d.rdata = {24'h0, s_q.jpg};
                `OAG_OFS_LADDR: s_d.rdata = {8'h0, s_q.last_addr};
                `OAG_OFS_LPC:   s_d.rdata = {10'h0, s_q.last_pc};
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q           <= '0;
            s_q.xpg       <= `OAG_PAGE_RST;
            s_q.ypg       <= `OAG_PAGE_RST;
            s_q.zpg       <= `OAG_PAGE_RST;
            s_q.dpg       <= `OAG_PAGE_RST;
            s_q.jpg       <= `OAG_PAGE_RST;
            s_q.last_addr <= `OAG_ADDR_RST;
            s_q.last_pc   <= `OAG_PC_RST;
            s_q.waitreq   <= 1'b1;
            s_q.space     <= SP_NONE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign out_valid       = s_q.out_valid;
    assign space           = s_q.space;
    assign data_addr       = s_q.data_addr;
    assign io_addr         = s_q.io_addr;
    assign bit_sel         = s_q.bit_sel;
    assign rd_addr         = s_q.rd_addr;
    assign rs_addr         = s_q.rs_addr;
    assign wr_addr         = s_q.wr_addr;
    assign wb_en           = s_q.wb_en;
    assign ptr_wb_en       = s_q.ptr_wb_en;
    assign ptr_wb_idx      = s_q.ptr_wb_idx;
    assign ptr_wb_val      = s_q.ptr_wb_val;
    assign pm_word         = s_q.pm_word;
    assign pm_hi           = s_q.pm_hi;
    assign pc_load         = s_q.pc_load;
    assign pc_val          = s_q.pc_val;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_ptr_pairs; // [RULE_01]
        req_valid && mode == M_IND && ptr_sel == 2'd2 |=>
            data_addr[15:0] == $past(rf_ptr_bytes[47:32]);
    endproperty
    a_ptr_pairs: assert property (p_ptr_pairs) // [RULE_01]
        else $error("third pointer not formed from pair 31:30");

    property p_bit_sel; // [RULE_02]
        req_valid |=> out_valid && bit_sel == $past(bit_field);
    endproperty
    a_bit_sel: assert property (p_bit_sel) // [RULE_02]
        else $error("bit select not taken from field");

    property p_disp; // [RULE_09]
        req_valid && mode == M_DISP |=>
            data_addr[15:0] == $past(ptr_cur) + {10'h000, $past(disp_field)}
            && !ptr_wb_en;
    endproperty
    a_disp: assert property (p_disp) // [RULE_09]
        else $error("displacement address wrong or pointer changed");

    property p_reg2; // [RULE_05]
        req_valid && mode == M_REG2 |=> wb_en &&
            wr_addr == $past(dst_reg) && rs_addr == $past(src_reg);
    endproperty
    a_reg2: assert property (p_reg2) // [RULE_05]
        else $error("two register result not to destination");

    property p_io; // [RULE_06]
        req_valid && mode == M_IO |=> space == SP_IO &&
            io_addr == $past(io_field) && data_addr < `OAG_EXTIO_LO;
    endproperty
    a_io: assert property (p_io) // [RULE_06]
        else $error("io direct address wrong");

    property p_direct; // [RULE_08]
        req_valid && mode == M_DIRECT |=>
            data_addr[15:0] == $past(word2) && !ptr_wb_en;
    endproperty
    a_direct: assert property (p_direct) // [RULE_08]
        else $error("direct address not second word");

    property p_predec; // [RULE_12]
        req_valid && mode == M_PREDEC |=> ptr_wb_en &&
            ptr_wb_val == data_addr[15:0] &&
            ptr_wb_val == $past(ptr_cur) - 16'h0001;
    endproperty
    a_predec: assert property (p_predec) // [RULE_12]
        else $error("pre-decrement address or write-back wrong");

    property p_postinc; // [RULE_13]
        req_valid && mode == M_POSTINC |=> ptr_wb_en &&
            data_addr[15:0] == $past(ptr_cur) &&
            ptr_wb_val == data_addr[15:0] + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc) // [RULE_13]
        else $error("post-increment address or write-back wrong");

    property p_pconst; // [RULE_14]
        req_valid && mode == M_PCONST |=> space == SP_PROG &&
            pm_hi == $past(rf_ptr_bytes[32]) &&
            pm_word == {8'h00, $past(rf_ptr_bytes[47:33])};
    endproperty
    a_pconst: assert property (p_pconst) // [RULE_14]
        else $error("constant read byte address split wrong");

    property p_pjmp; // [RULE_19]
        req_valid && mode == M_PJMP |=> pc_load &&
            pc_val == {6'h00, $past(rf_ptr_bytes[47:32])};
    endproperty
    a_pjmp: assert property (p_pjmp) // [RULE_19]
        else $error("pointer jump target wrong");

    property p_regfile; // [RULE_11]
        req_valid && mode == M_IND && ext_cur <= `OAG_REGF_TOP |=>
            space == SP_REGF;
    endproperty
    a_regfile: assert property (p_regfile) // [RULE_11]
        else $error("low data address did not hit registers");

    property p_bus_ack;
        (avs_read || avs_write) && avs_waitrequest |=>
            !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus answer not after one wait cycle");

endmodule // oag_top

/* test/oag_rf_model.sv */
// register file model holding the three pointer pairs
`timescale 1ns/10ps
module oag_rf_model
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ld_en,
    input  wire logic [47:0] ld_val,
    input  wire logic        ptr_wb_en,
    input  wire logic [4:0]  ptr_wb_idx,
    input  wire logic [15:0] ptr_wb_val,
    output logic      [47:0] rf_ptr_bytes
);
    logic [47:0] regs_q;

    // byte k is register 26+k, so each pair has its low byte in the lower bits
    assign rf_ptr_bytes = regs_q;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            regs_q <= 48'h000000000000;
        else if (ld_en)
            regs_q <= ld_val;
        else if (ptr_wb_en && ptr_wb_idx >= 5'h1A && !ptr_wb_idx[0])
            // whole pair at once: a wrap must reach the high byte too
            regs_q[(ptr_wb_idx - 5'h1A) * 8 +: 16] <= ptr_wb_val;
    end
endmodule // oag_rf_model

/* test/oag_top_tb.sv */
// self-checking bench for the operand address generator
`timescale 1ns/10ps
module oag_top_tb;
    import oag_pkg::*;

    logic        core_clk, nrst, req_valid, ld_en;
    oag_mode_t   mode;
    logic [1:0]  ptr_sel;
    logic [4:0]  dst_reg, src_reg, avs_address;
    logic [5:0]  io_field, disp_field;
    logic [2:0]  bit_field;
    logic [15:0] word2, ptr_wb_val;
    logic [21:0] imm_target, pc_val;
    logic [47:0] rf_ptr_bytes, ld_val;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        out_valid, wb_en, ptr_wb_en, pm_hi, pc_load;
    oag_space_t  space;
    logic [23:0] data_addr;
    logic [5:0]  io_addr;
    logic [2:0]  bit_sel;
    logic [4:0]  rd_addr, rs_addr, wr_addr, ptr_wb_idx;
    logic [22:0] pm_word;
    int          num_errors = 0;
    int          cmp_count = 0;

    oag_top u_oag_top (.core_clk(core_clk), .nrst(nrst),
        .req_valid(req_valid), .mode(mode), .ptr_sel(ptr_sel),
        .dst_reg(dst_reg), .src_reg(src_reg), .io_field(io_field),
        .disp_field(disp_field), .bit_field(bit_field), .word2(word2),
        .imm_target(imm_target), .rf_ptr_bytes(rf_ptr_bytes),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .out_valid(out_valid),
        .space(space), .data_addr(data_addr), .io_addr(io_addr),
        .bit_sel(bit_sel), .rd_addr(rd_addr), .rs_addr(rs_addr),
        .wr_addr(wr_addr), .wb_en(wb_en), .ptr_wb_en(ptr_wb_en),
        .ptr_wb_idx(ptr_wb_idx), .ptr_wb_val(ptr_wb_val),
        .pm_word(pm_word), .pm_hi(pm_hi), .pc_load(pc_load),
        .pc_val(pc_val));

    oag_rf_model u_oag_rf_model (.core_clk(core_clk), .nrst(nrst),
        .ld_en(ld_en), .ld_val(ld_val), .ptr_wb_en(ptr_wb_en),
        .ptr_wb_idx(ptr_wb_idx), .ptr_wb_val(ptr_wb_val),
        .rf_ptr_bytes(rf_ptr_bytes));

    task test_done;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge;
    // read data is taken at that same edge, then the request drops
    task av(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50)
            chk(32'h0, 32'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        av(1'b0, a, 32'h0, 4'hF, q);
        chk(q, e);
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        av(1'b1, a, d, be, q);
    endtask

    task setp(input logic [15:0] x, input logic [15:0] y,
              input logic [15:0] z);
        @(posedge core_clk);
        ld_en <= 1'b1;
        ld_val <= {z, y, x};
        @(posedge core_clk);
        ld_en <= 1'b0;
    endtask

    // one decode; outputs looked at in the cycle of the answer
    task dec(input oag_mode_t m, input logic [1:0] s, input logic [15:0] w);
        @(posedge core_clk);
        req_valid <= 1'b1;
        mode <= m;
        ptr_sel <= s;
        word2 <= w;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        chk(out_valid, 1);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        #(100 * 5000);
        num_errors++;
        test_done;
    end

    initial
    begin
        {nrst, req_valid, ld_en, avs_read, avs_write} = 5'h00;
        mode = M_REG1;
        {ptr_sel, word2, ld_val, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        dst_reg = 5'h11;
        src_reg = 5'h09;
        io_field = 6'h3F;
        disp_field = 6'h3F;
        bit_field = 3'h5;
        imm_target = 22'h3ABCDE;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
            rd(a[4:0], 32'h0);
        setp(16'h001F, 16'h1FFF, 16'hABCD);
        dec(M_IND, 2'h0, 16'h0);
        chk(data_addr, 24'h1F);
        chk(space, SP_REGF);
        dec(M_DIRECT, 2'h0, 16'h0060);
        chk(data_addr, 24'h60);
        chk(space, SP_EXTIO);
        dec(M_IO, 2'h0, 16'h0);
        chk(io_addr, 6'h3F);
        chk(space, SP_IO);
        dec(M_REG1, 2'h0, 16'h0);
        chk({rd_addr, wr_addr, wb_en}, {5'h11, 5'h11, 1'b1});
        chk(bit_sel, 3'h5);
        dec(M_REG2, 2'h0, 16'h0);
        chk({rs_addr, wr_addr, wb_en}, {5'h09, 5'h11, 1'b1});
        wr(5'h00, 32'h12, 4'hF);
        wr(5'h04, 32'h34, 4'hF);
        wr(5'h08, 32'h56, 4'hF);
        wr(5'h0C, 32'h78, 4'hF);
        wr(5'h10, 32'h3F, 4'hF);
        wr(5'h00, 32'hEE, 4'hE);
        wr(5'h1C, 32'hEE, 4'hF);
        rd(5'h00, 32'h12);
        rd(5'h08, 32'h56);
        rd(5'h1C, 32'h0);
        setp(16'h0100, 16'hFFFF, 16'hABCD);
        dec(M_PREDEC, 2'h0, 16'h0);
        chk(data_addr, 24'h1200FF);
        chk({ptr_wb_en, ptr_wb_idx, ptr_wb_val},
            {1'b1, 5'h1A, 16'h00FF});
        dec(M_IND, 2'h0, 16'h0);
        chk(data_addr, 24'h1200FF);
        wr(5'h14, 32'h0, 4'hF);
        rd(5'h14, 32'h1200FF);
        dec(M_POSTINC, 2'h1, 16'h0);
        chk(data_addr, 24'h34FFFF);
        chk({ptr_wb_idx, ptr_wb_val}, {5'h1C, 16'h0000});
        dec(M_DISP, 2'h1, 16'h0);
        chk({data_addr, ptr_wb_en},
            {24'h34003F, 1'b0});
        dec(M_PCONST, 2'h2, 16'h0);
        chk({pm_word, pm_hi}, {23'h0055E6, 1'b1});
        dec(M_EPCONST, 2'h2, 16'h0);
        chk(pm_word, 23'h2B55E6);
        dec(M_EPCONST_INC, 2'h2, 16'h0);
        chk({pm_word, ptr_wb_idx, ptr_wb_val},
            {23'h2B55E6, 5'h1E, 16'hABCE});
        dec(M_PCONST_INC, 2'h2, 16'h0);
        chk({pm_word, pm_hi, ptr_wb_val},
            {23'h0055E7, 1'b0, 16'hABCF});
        dec(M_DIRECT, 2'h0, 16'h1234);
        chk(data_addr, 24'h781234);
        chk(space, SP_MEM);
        dec(M_JMP, 2'h0, 16'h0);
        chk({pc_load, pc_val}, {1'b1, 22'h3ABCDE});
        dec(M_PJMP, 2'h2, 16'h0);
        chk(pc_val, 22'h00ABCF);
        dec(M_EPJMP, 2'h2, 16'h0);
        chk(pc_val, 22'h3FABCF);
        // software keeps bit 0 of the third pointer clear before a store
        setp(16'h0000, 16'h0000, 16'hABCE);
        dec(M_IND, 2'h2, 16'h0);
        chk(data_addr, 24'h56ABCE);
        dec(M_IND, 2'h3, 16'h0);
        chk(data_addr, 24'h56ABCE);
        dec(M_PSTORE, 2'h2, 16'h0);
        chk({pm_word, pm_hi}, {23'h0055E7, 1'b0});
        chk(space, SP_PROG);
        test_done;
    end
endmodule // oag_top_tb
